// >>> src/dfsl_map.vh
// constants for the disk function and status logic
// assumes codes arrive as 12-bit words, two controls, one clock
`ifndef DFSL_MAP_VH
`define DFSL_MAP_VH

// function codes
`define DFSL_FC_RELEASE   12'h0000
`define DFSL_FC_CLEAR     12'h0007
`define DFSL_FC_SEL_RNB   12'h0010
`define DFSL_FC_REL_RNB   12'h0011
`define DFSL_FC_SEL_EOP   12'h0012
`define DFSL_FC_REL_EOP   12'h0013
`define DFSL_FC_SEL_AEOP  12'h0014
`define DFSL_FC_REL_AEOP  12'h0015
`define DFSL_FC_READ      12'h0020
`define DFSL_FC_WRITE     12'h0021
`define DFSL_FC_CHECK     12'h0022
`define DFSL_FC_WCHECK    12'h0023
`define DFSL_FC_DSEARCH   12'h0024
`define DFSL_FC_IGN_A     12'h0025
`define DFSL_FC_ESEARCH   12'h0026
`define DFSL_FC_IGN_B     12'h0027
`define DFSL_FC_RETADDR   12'h0028
`define DFSL_FC_LOADADDR  12'h0029
`define DFSL_FC_IGN_LO    12'h002A
`define DFSL_FC_IGN_HI    12'h002F
`define DFSL_FC_READ_NE   12'h0030
`define DFSL_FC_CHECK_NE  12'h0032

// interrupt code fields
`define DFSL_IRQ_REL_BIT  0
`define DFSL_IRQ_SEL_LSB  1

// decoded operation classes
`define DFSL_OP_BAD       3'h0
`define DFSL_OP_REL       3'h1
`define DFSL_OP_CLR       3'h2
`define DFSL_OP_IRQ       3'h3
`define DFSL_OP_MODE      3'h4
`define DFSL_OP_RET       3'h5
`define DFSL_OP_LOAD      3'h6
`define DFSL_OP_IGN       3'h7

// operating modes
`define DFSL_MODE_NONE    3'h0
`define DFSL_MODE_READ    3'h1
`define DFSL_MODE_CHECK   3'h2
`define DFSL_MODE_WRITE   3'h3
`define DFSL_MODE_WCHECK  3'h4
`define DFSL_MODE_DSEARCH 3'h5
`define DFSL_MODE_ESEARCH 3'h6

// status word bit positions
`define DFSL_ST_READY     0
`define DFSL_ST_BUSY      1
`define DFSL_ST_ACC_UNAV  2
`define DFSL_ST_ON_TRACK  3
`define DFSL_ST_WR_PERMIT 4
`define DFSL_ST_LOST      5
`define DFSL_ST_SRCH_SAT  6
`define DFSL_ST_IRQ_LSB   7
`define DFSL_ST_CW_ERR    10
`define DFSL_ST_RSV_OTHER 11

// sizes and counts
`define DFSL_BYTE_W       12
`define DFSL_WORD_W       48
`define DFSL_ACW_LOW_W    13
`define DFSL_LOAD_LAST    4'h7
`define DFSL_ACW_BYTES    4'h4
`define DFSL_RET_LAST     2'h3
`define DFSL_RET_POS_LSB  7
`define DFSL_RET_CONN_LSB 24
`define DFSL_PAR_SENSE    1'b1
`define DFSL_SYNC_W       24
`define DFSL_FIFO_DEPTH   32
`define DFSL_FIFO_AW      5

`endif

// >>> src/dfsl_ctrl.v
// function code decoder, control words and status words for two disk controls
// assumes channel-side strobes are on sys_clk; drive pins and switches are asynchronous
// Summary of operation
// - release-and-disconnect frees unit, clears reservation, stops positioner
// - codes 0045, 0047, 0052-0057 get a reply and nothing else
// - clear code frees unit and clears reservation, positioner left active
// - mode holds until next mode code, channel clear or master clear
// - 0040 read mode; 0060 read with end-of-record suppressed
// - 0042 check read, checkword as byte 129; 0062 same without end-of-record
// - 0041 write mode; 0043 write with automatic verify
// - 0044 data search for stored search word; 0046 error search
// - 0050 returns four-byte word: sector, positioner address, connected unit
// - return-address rejected while seeking or off the addressed track
// - 0051 loads next eight bytes: four address word, four search word
// - each control keeps its own independent control words
// - interrupt holds until interrupt code, clear, or new transfer
// - interrupt driven on the line matching the equipment number
// - 0020 enables ready-and-not-busy interrupt; 0021 cancels it
// - 0022 enables end-of-operation interrupt; 0023 cancels it
// - 0024 enables abnormal-end interrupt; 0025 cancels it
// - one 12-bit status word per control, always readable
// - ready bit only when all drive conditions hold and no fault
// - busy bit during operations or seek; all codes with good parity rejected then
// - lost-data bit set on overrun, cleared by connect, mode or master clear
// - ready-not-busy bit set on transition only while selected
// - undefined codes are rejected
// - parity error: no reply, no reject, parity error flagged
`timescale 1ns/1ns
`include "dfsl_map.vh"

module dfsl_fifo #(
	parameter WIDTH = 13,
	parameter DEPTH = `DFSL_FIFO_DEPTH,
	parameter AW    = `DFSL_FIFO_AW
) (
	input  wire             sys_clk,
	input  wire             rst,
	input  wire             in_valid,
	input  wire [WIDTH-1:0] in_data,
	output wire             in_ready,
	output wire             out_valid,
	output wire [WIDTH-1:0] out_data,
	input  wire             out_ready
);
	reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_q;
	reg  [AW-1:0]    rd_ptr_q;
	reg  [AW:0]      count_q;
	reg  [AW:0]      count_d;
	reg              in_ready_q;
	wire             push;
	wire             pop;

	assign push      = in_valid & in_ready_q;
	assign pop       = out_valid & out_ready;
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign out_data  = mem_q[rd_ptr_q];
	assign in_ready  = in_ready_q;

	always @* begin
		count_d = count_q;
		if (push & ~pop)
			count_d = count_q + 1'b1;
		else if (pop & ~push)
			count_d = count_q - 1'b1;
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			wr_ptr_q   <= {AW{1'b0}};
			rd_ptr_q   <= {AW{1'b0}};
			count_q    <= {(AW+1){1'b0}};
			in_ready_q <= 1'b0;
		end else begin
			if (push) begin
				mem_q[wr_ptr_q] <= in_data;
				wr_ptr_q        <= wr_ptr_q + 1'b1;
			end
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			count_q <= count_d;
			// registered ready from the next count: full is seen in the cycle it is reached, never overrun
			in_ready_q <= (count_d < DEPTH);
		end
	end
endmodule // dfsl_fifo

module dfsl_ctrl (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        master_clr,
	input  wire [1:0]  chan_clr,
	input  wire [1:0]  connect_evt,
	input  wire [1:0]  io_start,
	input  wire [1:0]  func_valid,
	input  wire [23:0] func_code,
	input  wire [1:0]  func_par,
	output reg  [1:0]  func_reply_q,
	output reg  [1:0]  func_reject_q,
	output reg  [1:0]  par_err_q,
	input  wire        out_valid,
	input  wire        out_ctl,
	input  wire [11:0] out_data,
	output wire        out_ready,
	input  wire [1:0]  out_end,
	input  wire [1:0]  rd_req,
	output reg  [23:0] rd_data_q,
	output reg  [1:0]  rd_valid_q,
	input  wire [1:0]  pin_spin,
	input  wire [1:0]  pin_heads,
	input  wire [1:0]  pin_tests_off,
	input  wire [1:0]  pin_on_track,
	input  wire [1:0]  pin_no_fault,
	input  wire [1:0]  pin_wr_permit,
	input  wire [1:0]  pin_acc_unav,
	input  wire [1:0]  pin_rsv_other,
	input  wire [1:0]  pin_seek,
	input  wire [5:0]  equip_sw,
	input  wire [1:0]  xfer_busy,
	input  wire [1:0]  op_end,
	input  wire [1:0]  cw_err_evt,
	input  wire [1:0]  lost_evt,
	input  wire [1:0]  srch_hit,
	input  wire [13:0] last_sector,
	input  wire [11:0] last_pos,
	input  wire [13:0] conn_id,
	output reg  [5:0]  mode_q,
	output reg  [1:0]  eor_off_q,
	output reg  [1:0]  mode_pls_q,
	output reg  [1:0]  release_pls_q,
	output reg  [1:0]  pos_off_pls_q,
	output reg  [95:0] acw_q,
	output reg  [95:0] scw_q,
	output reg  [23:0] status_word_q,
	output reg  [15:0] int_line_q
);
	reg  [`DFSL_SYNC_W-1:0] sync1_q;
	reg  [`DFSL_SYNC_W-1:0] sync2_q;
	reg  [5:0]  irq_q;
	reg  [5:0]  irq_sel_q;
	reg  [1:0]  lost_q;
	reg  [1:0]  srch_q;
	reg  [1:0]  cw_q;
	reg  [1:0]  ld_act_q;
	reg  [7:0]  ld_cnt_q;
	reg  [1:0]  term_pend_q;
	reg  [1:0]  ret_act_q;
	reg  [3:0]  ret_cnt_q;
	reg  [1:0]  rnb_prev_q;
	reg  [1:0]  ready_prev_q;
	reg  [5:0]  op_c;
	reg  [1:0]  par_bad_c;
	reg  [1:0]  ready_c;
	reg  [1:0]  busy_c;
	reg  [1:0]  rej_c;
	reg  [95:0] ret_w_c;
	reg  [7:0]  mode_c;
	wire [1:0]  s_spin;
	wire [1:0]  s_heads;
	wire [1:0]  s_tests;
	wire [1:0]  s_track;
	wire [1:0]  s_fault_n;
	wire [1:0]  s_wp;
	wire [1:0]  s_acc;
	wire [1:0]  s_rsv;
	wire [1:0]  s_seek;
	wire [5:0]  s_equip;
	wire        fifo_valid;
	wire [12:0] fifo_data;
	wire        fifo_ready;
	integer     i;
	integer     j;

	// decode a function code into its class
	function [2:0] dfsl_op;
		input [11:0] fc;
		begin
			case (fc)
				`DFSL_FC_RELEASE:  dfsl_op = `DFSL_OP_REL;
				`DFSL_FC_CLEAR:    dfsl_op = `DFSL_OP_CLR;
				`DFSL_FC_SEL_RNB, `DFSL_FC_REL_RNB, `DFSL_FC_SEL_EOP,
				`DFSL_FC_REL_EOP, `DFSL_FC_SEL_AEOP, `DFSL_FC_REL_AEOP:
					dfsl_op = `DFSL_OP_IRQ;
				`DFSL_FC_READ, `DFSL_FC_WRITE, `DFSL_FC_CHECK, `DFSL_FC_WCHECK,
				`DFSL_FC_DSEARCH, `DFSL_FC_ESEARCH, `DFSL_FC_READ_NE, `DFSL_FC_CHECK_NE:
					dfsl_op = `DFSL_OP_MODE;
				`DFSL_FC_RETADDR:  dfsl_op = `DFSL_OP_RET;
				`DFSL_FC_LOADADDR: dfsl_op = `DFSL_OP_LOAD;
				`DFSL_FC_IGN_A, `DFSL_FC_IGN_B:
					dfsl_op = `DFSL_OP_IGN;
				default: begin
					if (fc >= `DFSL_FC_IGN_LO && fc <= `DFSL_FC_IGN_HI)
						dfsl_op = `DFSL_OP_IGN;
					else
						dfsl_op = `DFSL_OP_BAD;
				end
			endcase
		end
	endfunction

	// mode code to {end-of-record off, mode}
	function [3:0] dfsl_mode;
		input [11:0] fc;
		begin
			case (fc)
				`DFSL_FC_READ:     dfsl_mode = {1'b0, `DFSL_MODE_READ};
				`DFSL_FC_READ_NE:  dfsl_mode = {1'b1, `DFSL_MODE_READ};
				`DFSL_FC_CHECK:    dfsl_mode = {1'b0, `DFSL_MODE_CHECK};
				`DFSL_FC_CHECK_NE: dfsl_mode = {1'b1, `DFSL_MODE_CHECK};
				`DFSL_FC_WRITE:    dfsl_mode = {1'b0, `DFSL_MODE_WRITE};
				`DFSL_FC_WCHECK:   dfsl_mode = {1'b0, `DFSL_MODE_WCHECK};
				`DFSL_FC_DSEARCH:  dfsl_mode = {1'b0, `DFSL_MODE_DSEARCH};
				`DFSL_FC_ESEARCH:  dfsl_mode = {1'b0, `DFSL_MODE_ESEARCH};
				default:           dfsl_mode = {1'b0, `DFSL_MODE_NONE};
			endcase
		end
	endfunction

	function [7:0] dfsl_line;
		input [2:0] num;
		begin
			dfsl_line = 8'h01 << num;
		end
	endfunction

	assign {s_equip, s_seek, s_rsv, s_acc, s_wp, s_fault_n, s_track, s_tests, s_heads, s_spin} = sync2_q;

	// drain stalls while a return byte is read: one shared update slot per cycle
	dfsl_fifo #(
		.WIDTH (13),
		.DEPTH (`DFSL_FIFO_DEPTH),
		.AW    (`DFSL_FIFO_AW)
	) dfsl_fifo_i (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (out_valid),
		.in_data   ({out_ctl, out_data}),
		.in_ready  (out_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (fifo_ready)
	);
	assign fifo_ready = ~(|rd_req);

	always @* begin
		op_c      = 6'h00;
		par_bad_c = 2'h0;
		ready_c   = 2'h0;
		busy_c    = 2'h0;
		rej_c     = 2'h0;
		ret_w_c   = 96'h0;
		mode_c    = 8'h00;
		for (j = 0; j < 2; j = j + 1) begin
			op_c[j*3 +: 3]   = dfsl_op(func_code[j*12 +: 12]);
			mode_c[j*4 +: 4] = dfsl_mode(func_code[j*12 +: 12]);
			par_bad_c[j]     = ((^{func_code[j*12 +: 12], func_par[j]}) != `DFSL_PAR_SENSE);
			ready_c[j] = s_spin[j] & s_heads[j] & s_tests[j] & s_track[j] & s_fault_n[j];
			busy_c[j] = xfer_busy[j] | s_seek[j] | ld_act_q[j] | ret_act_q[j];
			rej_c[j] = busy_c[j] | (op_c[j*3 +: 3] == `DFSL_OP_BAD);
			// return address needs positioner settled on track
			if (op_c[j*3 +: 3] == `DFSL_OP_RET && (s_seek[j] | ~s_track[j]))
				rej_c[j] = 1'b1;
			ret_w_c[j*48 +: 7]                            = last_sector[j*7 +: 7];
			ret_w_c[j*48 + `DFSL_RET_POS_LSB +: 6]       = last_pos[j*6 +: 6];
			ret_w_c[j*48 + `DFSL_RET_CONN_LSB +: 7]      = conn_id[j*7 +: 7];
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			sync1_q       <= {`DFSL_SYNC_W{1'b0}};
			sync2_q       <= {`DFSL_SYNC_W{1'b0}};
			func_reply_q  <= 2'h0;
			func_reject_q <= 2'h0;
			par_err_q     <= 2'h0;
			rd_data_q     <= 24'h0;
			rd_valid_q    <= 2'h0;
			mode_q        <= 6'h00;
			eor_off_q     <= 2'h0;
			mode_pls_q    <= 2'h0;
			release_pls_q <= 2'h0;
			pos_off_pls_q <= 2'h0;
			acw_q         <= 96'h0;
			scw_q         <= 96'h0;
			status_word_q <= 24'h0;
			int_line_q    <= 16'h0;
			irq_q         <= 6'h00;
			irq_sel_q     <= 6'h00;
			lost_q        <= 2'h0;
			srch_q        <= 2'h0;
			cw_q          <= 2'h0;
			ld_act_q      <= 2'h0;
			ld_cnt_q      <= 8'h00;
			term_pend_q   <= 2'h0;
			ret_act_q     <= 2'h0;
			ret_cnt_q     <= 4'h0;
			rnb_prev_q    <= 2'h0;
			ready_prev_q  <= 2'h0;
		end else begin
			sync1_q <= {equip_sw, pin_seek, pin_rsv_other, pin_acc_unav, pin_wr_permit,
				pin_no_fault, pin_on_track, pin_tests_off, pin_heads, pin_spin};
			sync2_q <= sync1_q;
			func_reply_q  <= 2'h0;
			func_reject_q <= 2'h0;
			mode_pls_q    <= 2'h0;
			release_pls_q <= 2'h0;
			pos_off_pls_q <= 2'h0;
			rd_valid_q    <= 2'h0;
			for (i = 0; i < 2; i = i + 1) begin
				rnb_prev_q[i]   <= ready_c[i] & ~busy_c[i];
				ready_prev_q[i] <= ready_c[i];

				// clears of sticky flags come first so a same-cycle event wins
				if (connect_evt[i] | master_clr)
					lost_q[i] <= 1'b0;
				if (connect_evt[i] | master_clr | chan_clr[i]) begin
					srch_q[i] <= 1'b0;
					cw_q[i]   <= 1'b0;
				end
				if (io_start[i] | master_clr | chan_clr[i])
					irq_q[i*3 +: 3] <= 3'h0;

				if (func_valid[i]) begin
					if (par_bad_c[i])
						par_err_q[i] <= 1'b1;
					else if (rej_c[i])
						func_reject_q[i] <= 1'b1;
					else begin
						func_reply_q[i] <= 1'b1;
						case (op_c[i*3 +: 3])
							`DFSL_OP_REL: begin
								release_pls_q[i] <= 1'b1;
								pos_off_pls_q[i] <= 1'b1;
							end
							`DFSL_OP_CLR: begin
								release_pls_q[i] <= 1'b1;
							end
							`DFSL_OP_IRQ: begin
								// any interrupt code clears all three
								irq_q[i*3 +: 3] <= 3'h0;
								// select or cancel per code pair
								irq_sel_q[i*3 + func_code[i*12 + `DFSL_IRQ_SEL_LSB +: 2]] <=
									~func_code[i*12 + `DFSL_IRQ_REL_BIT];
							end
							`DFSL_OP_MODE: begin
								mode_q[i*3 +: 3] <= mode_c[i*4 +: 3];
								eor_off_q[i]     <= mode_c[i*4 + 3];
								mode_pls_q[i]    <= 1'b1;
								lost_q[i]        <= 1'b0;
								srch_q[i]        <= 1'b0;
								cw_q[i]          <= 1'b0;
							end
							`DFSL_OP_RET: begin
								ret_act_q[i]        <= 1'b1;
								ret_cnt_q[i*2 +: 2] <= 2'h0;
							end
							`DFSL_OP_LOAD: begin
								// start load, low address field cleared
								ld_act_q[i]        <= 1'b1;
								ld_cnt_q[i*4 +: 4] <= 4'h0;
								term_pend_q[i]     <= 1'b0;
								acw_q[i*48 +: `DFSL_ACW_LOW_W] <= {`DFSL_ACW_LOW_W{1'b0}};
							end
							default: ;
						endcase
					end
				end

				// return word out, four bytes low first
				if (rd_req[i] & ret_act_q[i]) begin
					rd_data_q[i*12 +: 12] <= ret_w_c[i*48 + ret_cnt_q[i*2 +: 2]*12 +: 12];
					rd_valid_q[i]         <= 1'b1;
					ret_cnt_q[i*2 +: 2]   <= ret_cnt_q[i*2 +: 2] + 2'h1;
					if (ret_cnt_q[i*2 +: 2] == `DFSL_RET_LAST)
						ret_act_q[i] <= 1'b0;
				end

				// load bytes into address then search word
				if (fifo_valid & fifo_ready & (fifo_data[12] == i[0]) & ld_act_q[i]) begin
					if (ld_cnt_q[i*4 +: 4] < `DFSL_ACW_BYTES)
						acw_q[i*48 + ld_cnt_q[i*4 +: 4]*12 +: 12] <= fifo_data[11:0];
					else
						scw_q[i*48 + (ld_cnt_q[i*4 +: 4] - `DFSL_ACW_BYTES)*12 +: 12] <= fifo_data[11:0];
					ld_cnt_q[i*4 +: 4] <= ld_cnt_q[i*4 +: 4] + 4'h1;
					if (ld_cnt_q[i*4 +: 4] == `DFSL_LOAD_LAST)
						ld_act_q[i] <= 1'b0;
				end
				// short load ends once queued bytes are drained
				if (out_end[i] & ld_act_q[i])
					term_pend_q[i] <= 1'b1;
				if (term_pend_q[i] & ~fifo_valid) begin
					ld_act_q[i]    <= 1'b0;
					term_pend_q[i] <= 1'b0;
				end

				// sticky event sets win over same-cycle clears
				// lost data
				if (lost_evt[i])
					lost_q[i] <= 1'b1;
				if (srch_hit[i])
					srch_q[i] <= 1'b1;
				if (cw_err_evt[i])
					cw_q[i] <= 1'b1;
				if (irq_sel_q[i*3] & ready_c[i] & ~busy_c[i] & ~rnb_prev_q[i])
					irq_q[i*3] <= 1'b1;
				if (irq_sel_q[i*3 + 1] & op_end[i])
					irq_q[i*3 + 1] <= 1'b1;
				if (irq_sel_q[i*3 + 2] & (cw_err_evt[i] | lost_evt[i] | (ready_prev_q[i] & ~ready_c[i])))
					irq_q[i*3 + 2] <= 1'b1;

				int_line_q[i*8 +: 8] <= (|irq_q[i*3 +: 3]) ? dfsl_line(s_equip[i*3 +: 3]) : 8'h00;

				status_word_q[i*12 + `DFSL_ST_READY]     <= ready_c[i];
				status_word_q[i*12 + `DFSL_ST_BUSY]      <= busy_c[i];
				status_word_q[i*12 + `DFSL_ST_ACC_UNAV]  <= s_acc[i];
				status_word_q[i*12 + `DFSL_ST_ON_TRACK]  <= s_track[i];
				status_word_q[i*12 + `DFSL_ST_WR_PERMIT] <= s_wp[i];
				status_word_q[i*12 + `DFSL_ST_LOST]      <= lost_q[i];
				status_word_q[i*12 + `DFSL_ST_SRCH_SAT]  <= srch_q[i];
				status_word_q[i*12 + `DFSL_ST_IRQ_LSB +: 3] <= irq_q[i*3 +: 3];
				status_word_q[i*12 + `DFSL_ST_CW_ERR]    <= cw_q[i];
				status_word_q[i*12 + `DFSL_ST_RSV_OTHER] <= s_rsv[i];

				// channel or master clear drops mode and control words
				if (master_clr | chan_clr[i]) begin
					mode_q[i*3 +: 3] <= `DFSL_MODE_NONE;
					eor_off_q[i]     <= 1'b0;
					irq_sel_q[i*3 +: 3] <= 3'h0;
					par_err_q[i]     <= 1'b0;
					ld_act_q[i]      <= 1'b0;
					term_pend_q[i]   <= 1'b0;
					ret_act_q[i]     <= 1'b0;
					acw_q[i*48 +: 48] <= 48'h0000_0000_0000;
					scw_q[i*48 +: 48] <= 48'h0000_0000_0000;
				end
			end
		end
	end
endmodule // dfsl_ctrl

// >>> testbench/dfsl_ctrl_sva.sv
// assertions on the function port, modes, pulses and interrupt line of control 0
// assumes equip_sw stays fixed while an interrupt is up
`timescale 1ns/1ns
`include "dfsl_map.vh"
module dfsl_ctrl_chk (
	input wire        sys_clk,
	input wire        rst,
	input wire        master_clr,
	input wire [1:0]  chan_clr,
	input wire [1:0]  io_start,
	input wire [1:0]  func_valid,
	input wire [23:0] func_code,
	input wire [1:0]  func_par,
	input wire [1:0]  func_reply_q,
	input wire [1:0]  func_reject_q,
	input wire [1:0]  par_err_q,
	input wire [1:0]  xfer_busy,
	input wire [1:0]  lost_evt,
	input wire [5:0]  equip_sw,
	input wire [5:0]  mode_q,
	input wire [1:0]  eor_off_q,
	input wire [1:0]  mode_pls_q,
	input wire [1:0]  release_pls_q,
	input wire [1:0]  pos_off_pls_q,
	input wire [23:0] status_word_q,
	input wire [15:0] int_line_q
);
	wire [11:0] fc0   = func_code[11:0];
	wire        good0 = func_valid[0] & (^{fc0, func_par[0]});
	wire        irq0  = |int_line_q[7:0];
	// any of the six interrupt codes, a clear or a new transfer may drop the line
	wire        clr0  = rst | master_clr | chan_clr[0] | io_start[0] |
		(good0 & (fc0 >= `DFSL_FC_SEL_RNB) & (fc0 <= `DFSL_FC_REL_AEOP));

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_PARITY: assert property (
		func_valid[0] && !(^{fc0, func_par[0]}) && !chan_clr[0] && !master_clr
		|=> !func_reply_q[0] && !func_reject_q[0] && par_err_q[0]) else $error("parity fault not handled");
	AST_BUSY_REJ: assert property (
		good0 && xfer_busy[0] && $past(xfer_busy[0]) |=> func_reject_q[0] && !func_reply_q[0])
		else $error("code accepted while busy");
	AST_UNDEF: assert property (
		good0 && !(fc0 inside {`DFSL_FC_RELEASE, `DFSL_FC_CLEAR, [`DFSL_FC_SEL_RNB:`DFSL_FC_REL_AEOP],
		[`DFSL_FC_READ:`DFSL_FC_READ_NE], `DFSL_FC_CHECK_NE}) |=> func_reject_q[0])
		else $error("undefined code not rejected");
	AST_READ_NE: assert property (
		good0 && fc0 == `DFSL_FC_READ_NE ##1 func_reply_q[0] |-> mode_q[2:0] == `DFSL_MODE_READ && eor_off_q[0])
		else $error("read without end of record not set");
	AST_RELEASE: assert property (
		good0 && fc0 == `DFSL_FC_RELEASE ##1 func_reply_q[0] |-> release_pls_q[0] && pos_off_pls_q[0])
		else $error("release without positioner stop");
	AST_CLEAR: assert property (
		good0 && fc0 == `DFSL_FC_CLEAR ##1 func_reply_q[0] |-> release_pls_q[0] && !pos_off_pls_q[0])
		else $error("clear code pulses wrong");
	AST_MODE_HOLD: assert property (
		!$stable(mode_q[2:0]) |-> mode_pls_q[0] || $past(chan_clr[0]) || $past(master_clr) || $past(rst))
		else $error("mode changed without cause");
	AST_INT_LINE: assert property (
		irq0 |-> int_line_q[7:0] == (8'h01 << equip_sw[2:0])) else $error("interrupt on wrong line");
	AST_INT_HOLD: assert property (
		$fell(irq0) |-> $past(clr0, 2) || $past(rst)) else $error("interrupt dropped without cause");
	AST_LOST: assert property (
		mode_pls_q[0] && !$past(lost_evt[0]) |=> !status_word_q[`DFSL_ST_LOST])
		else $error("lost data kept after mode code");
endmodule // dfsl_ctrl_chk

bind dfsl_ctrl dfsl_ctrl_chk dfsl_ctrl_chk_i (.sys_clk(sys_clk), .rst(rst), .master_clr(master_clr),
	.chan_clr(chan_clr), .io_start(io_start), .func_valid(func_valid), .func_code(func_code),
	.func_par(func_par), .func_reply_q(func_reply_q), .func_reject_q(func_reject_q), .par_err_q(par_err_q),
	.xfer_busy(xfer_busy), .lost_evt(lost_evt), .equip_sw(equip_sw), .mode_q(mode_q), .eor_off_q(eor_off_q),
	.mode_pls_q(mode_pls_q), .release_pls_q(release_pls_q), .pos_off_pls_q(pos_off_pls_q),
	.status_word_q(status_word_q), .int_line_q(int_line_q));

// >>> testbench/dfsl_chan_model.sv
// data channel model: issues function codes on one control and collects the answer
// assumes the controller answers on the same edge that it takes a code
`timescale 1ns/1ns
module dfsl_chan_model (
	input  wire [1:0]  func_reply_q,
	input  wire [1:0]  func_reject_q,
	input  wire        sys_clk,
	output reg  [1:0]  func_valid,
	output reg  [23:0] func_code,
	output reg  [1:0]  func_par
);
	initial begin
		func_valid = 2'h0;
		func_code  = 24'h0;
		func_par   = 2'h0;
	end
	// bad flips the parity bit so the code arrives corrupted
	task issue(input integer c, input [11:0] code, input bad, output [1:0] res);
		integer n;
		begin
			@(negedge sys_clk);
			func_code[12 * c +: 12] = code;
			func_par[c]             = ~(^code) ^ bad;
			func_valid[c]           = 1'b1;
			@(negedge sys_clk);
			func_valid[c]           = 1'b0;
			// inverse after release so a stale code can never pass for a new one
			func_code[12 * c +: 12] = ~code;
			res = {func_reject_q[c], func_reply_q[c]};
			// bounded wait, silence means a parity failure
			for (n = 0; n < 3 && res == 2'b00; n = n + 1) begin
				@(negedge sys_clk);
				res = {func_reject_q[c], func_reply_q[c]};
			end
		end
	endtask
endmodule // dfsl_chan_model

// >>> testbench/dfsl_ctrl_tb_top.sv
// self-checking bench for the disk function and status logic
// assumes the channel model drives the function port; other inputs change on falling edges
`timescale 1ns/1ns
`include "dfsl_map.vh"
module dfsl_ctrl_tb_top;
	// {eor off, mode, code} per mode select code, esearch last
	localparam [127:0] MODES = 128'h1020_9030_2022_a032_3021_4023_5024_6026;
	localparam [47:0]  RET   = {17'h0, 7'h5b, 11'h0, 6'h15, 7'h2a};
	reg         sys_clk = 1'b0, rst = 1'b1, master_clr = 1'b0, out_valid = 1'b0, out_ctl = 1'b0;
	reg  [11:0] out_data = 12'h0, last_pos = 12'h0, c12;
	reg  [13:0] last_sector = 14'h0, conn_id = 14'h0;
	reg  [5:0]  equip_sw = 6'h15;
	reg  [1:0]  chan_clr = 2'h0, io_start = 2'h0, rd_req = 2'h0, xfer_busy = 2'h0, op_end = 2'h0, res;
	reg  [1:0]  lost_evt = 2'h0, spin = 2'h1, heads = 2'h1, tst_off = 2'h1, on_trk = 2'h1, no_flt = 2'h1;
	reg  [1:0]  seek = 2'h0, wr_ok = 2'h2, acc_un = 2'h2, rsv_oth = 2'h2;
	wire [1:0]  func_valid, func_par, reply, reject, par_err, rd_valid, eor_off, mode_pls, rel_pls, pos_pls;
	wire [23:0] func_code, rd_data, status;
	wire [95:0] acw, scw;
	wire [5:0]  mode;
	wire [15:0] int_line;
	wire        out_ready;
	integer     errors = 0, tests_run = 0, ntest = 0, cycles = 0, k;

	dfsl_ctrl dfsl_ctrl_i (.sys_clk(sys_clk), .rst(rst), .master_clr(master_clr), .chan_clr(chan_clr),
		.connect_evt(2'h0), .io_start(io_start), .func_valid(func_valid), .func_code(func_code),
		.func_par(func_par), .func_reply_q(reply), .func_reject_q(reject), .par_err_q(par_err),
		.out_valid(out_valid), .out_ctl(out_ctl), .out_data(out_data), .out_ready(out_ready), .out_end(2'h0),
		.rd_req(rd_req), .rd_data_q(rd_data), .rd_valid_q(rd_valid), .pin_spin(spin), .pin_heads(heads),
		.pin_tests_off(tst_off), .pin_on_track(on_trk), .pin_no_fault(no_flt), .pin_wr_permit(wr_ok),
		.pin_acc_unav(acc_un), .pin_rsv_other(rsv_oth), .pin_seek(seek), .equip_sw(equip_sw),
		.xfer_busy(xfer_busy), .op_end(op_end), .cw_err_evt(2'h0), .lost_evt(lost_evt), .srch_hit(2'h0),
		.last_sector(last_sector), .last_pos(last_pos), .conn_id(conn_id), .mode_q(mode),
		.eor_off_q(eor_off), .mode_pls_q(mode_pls), .release_pls_q(rel_pls), .pos_off_pls_q(pos_pls),
		.acw_q(acw), .scw_q(scw), .status_word_q(status), .int_line_q(int_line));
	dfsl_chan_model dfsl_chan_model_i (.sys_clk(sys_clk), .func_reply_q(reply), .func_reject_q(reject),
		.func_valid(func_valid), .func_code(func_code), .func_par(func_par));

	initial forever #2 sys_clk = ~sys_clk;

	task tick(input integer n);
		repeat (n) @(negedge sys_clk);
	endtask
	task cmp(input [63:0] got, input [63:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task fc(input integer c, input [11:0] code, input [1:0] exp);
		begin
			dfsl_chan_model_i.issue(c, code, 1'b0, res);
			cmp(res, exp);
		end
	endtask
	// one load byte for control 1, held until the buffer takes it
	task push(input [11:0] d);
		begin
			out_valid = 1'b1;
			out_ctl   = 1'b1;
			out_data  = d;
			while (!out_ready) @(negedge sys_clk);
			@(negedge sys_clk);
			out_valid = 1'b0;
			out_data  = ~d;
			@(negedge sys_clk);
		end
	endtask
	task done;
		begin
			ntest = ntest + 1;
			$display("test %0d done, %0d errors so far", ntest, errors);
		end
	endtask
	task print_verdict;
		begin
			$display("comparisons %0d, mismatches %0d", tests_run, errors);
			if (errors == 0 && tests_run > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask

	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 6000) begin
			errors = errors + 1;
			print_verdict;
		end
	end

	initial begin
		tick(8);
		rst = 1'b0;
		tick(5);
		cmp({mode, status[23:12]}, {6'h0, 12'h814});
		cmp(status[0], 1'b1);
		heads[0] = 1'b0;
		tick(5);
		cmp(status[0], 1'b0);
		heads[0] = 1'b1;
		tick(5);
		fc(0, `DFSL_FC_SEL_RNB, 2'b01);
		tick(4);
		cmp(status[7], 1'b0);
		spin[0] = 1'b0;
		tick(5);
		spin[0] = 1'b1;
		tick(5);
		cmp({status[7], int_line[7:0]}, {1'b1, 8'h20});
		fc(0, `DFSL_FC_REL_RNB, 2'b01);
		tick(2);
		cmp({status[7], int_line[7:0]}, 9'h0);
		done;
		for (k = 0; k < 8; k = k + 1) begin
			fc(0, MODES[16 * (7 - k) +: 12], 2'b01);
			cmp({mode_pls[0], eor_off[0], mode[2:0]}, {1'b1, MODES[16 * (7 - k) + 12 +: 4]});
		end
		for (k = 0; k < 8; k = k + 1) begin
			c12 = (k < 2) ? 12'h0025 + {k[10:0], 1'b0} : 12'h0028 + k[11:0];
			fc(0, c12, 2'b01);
			cmp(mode[2:0], `DFSL_MODE_ESEARCH);
		end
		fc(0, 12'h0001, 2'b10);
		fc(0, 12'h0031, 2'b10);
		dfsl_chan_model_i.issue(0, `DFSL_FC_READ, 1'b1, res);
		cmp({res, par_err[0]}, 3'b001);
		chan_clr[0] = 1'b1;
		tick(1);
		chan_clr[0] = 1'b0;
		tick(2);
		cmp({par_err[0], mode[2:0]}, 4'h0);
		fc(0, `DFSL_FC_RELEASE, 2'b01);
		cmp({rel_pls[0], pos_pls[0]}, 2'b11);
		fc(0, `DFSL_FC_CLEAR, 2'b01);
		cmp({rel_pls[0], pos_pls[0]}, 2'b10);
		done;
		xfer_busy[0] = 1'b1;
		tick(2);
		cmp(status[1], 1'b1);
		fc(0, `DFSL_FC_READ, 2'b10);
		xfer_busy[0] = 1'b0;
		fc(0, `DFSL_FC_SEL_EOP, 2'b01);
		op_end[0] = 1'b1;
		tick(1);
		op_end[0] = 1'b0;
		tick(8);
		cmp({status[8], int_line[7:0]}, {1'b1, 8'h20});
		fc(0, `DFSL_FC_REL_AEOP, 2'b01);
		tick(2);
		cmp({status[8], int_line[7:0]}, 9'h0);
		fc(0, `DFSL_FC_REL_EOP, 2'b01);
		op_end[0] = 1'b1;
		tick(1);
		op_end[0] = 1'b0;
		tick(4);
		cmp({status[8], int_line[7:0]}, 9'h0);
		fc(0, `DFSL_FC_SEL_AEOP, 2'b01);
		lost_evt[0] = 1'b1;
		tick(1);
		lost_evt[0] = 1'b0;
		tick(3);
		cmp({status[9], status[5], int_line[7:0]}, {2'b11, 8'h20});
		io_start[0] = 1'b1;
		tick(1);
		io_start[0] = 1'b0;
		tick(3);
		cmp({status[9], status[5], int_line[7:0]}, {2'b01, 8'h00});
		fc(0, `DFSL_FC_WRITE, 2'b01);
		tick(2);
		cmp(status[5], 1'b0);
		done;
		seek[0] = 1'b1;
		tick(6);
		fc(0, `DFSL_FC_RETADDR, 2'b10);
		seek[0] = 1'b0;
		on_trk[0] = 1'b0;
		tick(6);
		fc(0, `DFSL_FC_RETADDR, 2'b10);
		on_trk[0] = 1'b1;
		last_sector = 14'h002a;
		last_pos = 12'h0015;
		conn_id = 14'h005b;
		tick(6);
		fc(0, `DFSL_FC_RETADDR, 2'b01);
		for (k = 0; k < 4; k = k + 1) begin
			rd_req[0] = 1'b1;
			tick(1);
			rd_req[0] = 1'b0;
			cmp({rd_valid[0], rd_data[11:0]}, {1'b1, RET[12 * k +: 12]});
			tick(1);
		end
		tick(2);
		fc(0, `DFSL_FC_READ, 2'b01);
		fc(1, `DFSL_FC_LOADADDR, 2'b01);
		tick(1);
		cmp(status[13], 1'b1);
		fc(1, `DFSL_FC_READ, 2'b10);
		for (k = 0; k < 8; k = k + 1)
			push(12'h05a0 + k[11:0]);
		tick(20);
		cmp(acw[95:48], 48'h5a35_a25a_15a0);
		cmp(scw[95:48], 48'h5a75_a65a_55a4);
		cmp({status[13], acw[47:0]}, 49'h0);
		master_clr = 1'b1;
		tick(1);
		master_clr = 1'b0;
		tick(2);
		cmp({mode, acw[95:48]}, 54'h0);
		done;
		print_verdict;
	end
endmodule // dfsl_ctrl_tb_top
